// ==== verilog/irt_timer.sv ====
// irt_timer: 8-bit interval / auto-reload timer with square-wave pin stage,
// registers reached over AXI4-Lite.
// assumes one clock aclk (40 MHz) and a synchronous active-low reset aresetn;
// the shared pin's port logic and the interrupt controller live outside.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps

// Function
// [R01] counter counts up one per prescaler tick picked by the clock select field
// [R02] stepping past maximum count sets the overflow flag in both modes
// [R03] reset clears the counter to zero
// [R04] counter and reload share one address: read counter, write reload
// [R05] writing reload also loads the counter immediately; counting continues from there
// [R06] interval mode wraps the counter to zero on overflow
// [R07] auto-reload mode loads the reload value on overflow, periods 1 to 256
// [R08] reset clears the reload register to zero
// [R09] after reset counting starts at once in interval mode
// [R10] interrupt request only while overflow flag and its enable are both set
// [R11] accepting interrupt leaves flag set; software clears it by writing
// [R12] irq select makes pin an input; else port, or driven low when output off
// [R13] output on, toggle select zero: 50% square at clock/2048 or clock/1024
// [R14] output on, toggle select one: pin inverts on every overflow
// [R15] software should use auto-reload mode for variable frequency output
// [R16] pin-control low four bits read one and ignore writes
// [R17] pin-control resets to upper bits zero, low bits one
// [R18] counter reads never stop or disturb the count
// [R19] clock select codes 0..7 pick /8192,/4096,/2048,/512,/256,/128,/32,/8
// [R20] mode register resets with mode and clock zero, middle bits one
// [R21] prescaler taps are one-cycle enables; all state updates synchronously
// [R22] reload write beats a same-cycle overflow in the counter; flag still set
module irt_timer (
  input wire logic aclk, // system clock, 40 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [4:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [4:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic overflow_irq, // interrupt request to cpu, active high level
  output logic wave_out_pin, // square-wave output level
  output logic wave_out_oe, // high while the timer drives the shared pin
  output logic pin_is_port, // shared pin left to the general port logic
  output logic pin_is_irq_input // shared pin used as external interrupt input
);

  typedef enum logic [1:0] {
    IRT_W_IDLE = 2'b00,
    IRT_W_RESP = 2'b01
  } irt_wstate_e;

  irt_wstate_e wstate_q;
  logic aw_have_q;
  logic w_have_q;
  logic [4:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic [7:0] count_q;
  logic [7:0] reload_q;
  logic reload_mode_q;
  logic [2:0] clock_select_q;
  logic out_func_select_q;
  logic wave_output_on_q;
  logic fixed_rate_pick_q;
  logic toggle_rate_pick_q;
  logic irq_pin_select_q;
  logic overflow_flag_q;
  logic overflow_irq_enable_q;
  logic [irt_pkg::PRESC_W-1:0] presc_q;
  logic [irt_pkg::PRESC_W-1:0] presc_next;
  logic [irt_pkg::PRESC_W-1:0] presc_rise;
  logic tick;
  logic overflow;
  logic toggle_q;
  logic fixed_wave;
  logic wave_q;

  logic wr_fire;
  logic wr_lane0;
  logic [7:0] wr_byte;
  logic wr_count;
  logic wr_mode;
  logic wr_pin;
  logic wr_pin1;
  logic wr_irqreq;
  logic wr_irqen;
  logic wr_mapped;
  logic [7:0] mode_rd;
  logic [7:0] pin_rd;
  logic [7:0] rd_byte;
  logic rd_mapped;

  // write channels: each address and data phase is taken once, in either order
  assign s_axi_awready = (wstate_q == IRT_W_IDLE) && !aw_have_q;
  assign s_axi_wready = (wstate_q == IRT_W_IDLE) && !w_have_q;
  assign s_axi_bvalid = (wstate_q == IRT_W_RESP);
  assign s_axi_bresp = bresp_q;
  assign wr_fire = (wstate_q == IRT_W_IDLE) && aw_have_q && w_have_q;
  assign wr_lane0 = wr_fire && wstrb_q[0];
  assign wr_byte = wdata_q[7:0];

  // write address decode; only byte lane 0 carries register bits
  always_comb begin
    wr_count = 1'b0;
    wr_mode = 1'b0;
    wr_pin = 1'b0;
    wr_pin1 = 1'b0;
    wr_irqreq = 1'b0;
    wr_irqen = 1'b0;
    wr_mapped = 1'b1;
    unique case (awaddr_q)
      irt_pkg::OFS_MODE: wr_mode = wr_lane0;
      irt_pkg::OFS_COUNT: wr_count = wr_lane0; // R04
      irt_pkg::OFS_PINCTL: wr_pin = wr_lane0;
      irt_pkg::OFS_PINMODE1: wr_pin1 = wr_lane0;
      irt_pkg::OFS_IRQREQ: wr_irqreq = wr_lane0;
      irt_pkg::OFS_IRQEN: wr_irqen = wr_lane0;
      default: wr_mapped = 1'b0;
    endcase
  end

  // write handshake sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_q <= IRT_W_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bresp_q <= irt_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[4:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      unique case (wstate_q)
        IRT_W_IDLE: begin
          if (wr_fire) begin
            wstate_q <= IRT_W_RESP;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bresp_q <= wr_mapped ? irt_pkg::RESP_OKAY : irt_pkg::RESP_SLVERR;
          end
        end
        IRT_W_RESP: begin
          if (s_axi_bready) begin
            wstate_q <= IRT_W_IDLE;
          end
        end
      endcase
    end
  end

  // readable views; fixed-one bits are forced, not stored
  assign mode_rd = {reload_mode_q, 4'hF, clock_select_q} | irt_pkg::MODE_FIXED_ONES;
  assign pin_rd = {out_func_select_q, wave_output_on_q, fixed_rate_pick_q, toggle_rate_pick_q, 4'h0}
                  | irt_pkg::PIN_FIXED_ONES; // R16

  // read decode; the counter is only sampled, never touched
  always_comb begin
    rd_byte = 8'h00;
    rd_mapped = 1'b1;
    unique case ({s_axi_araddr[4:2], 2'b00})
      irt_pkg::OFS_MODE: rd_byte = mode_rd;
      irt_pkg::OFS_COUNT: rd_byte = count_q; // R04 R18
      irt_pkg::OFS_PINCTL: rd_byte = pin_rd;
      irt_pkg::OFS_PINMODE1: rd_byte = {2'b00, irq_pin_select_q, 5'h00};
      irt_pkg::OFS_IRQREQ: rd_byte = {7'h00, overflow_flag_q};
      irt_pkg::OFS_IRQEN: rd_byte = {7'h00, overflow_irq_enable_q};
      default: rd_mapped = 1'b0;
    endcase
  end

  // read channel: one outstanding read, data held until rready
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= irt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_mapped ? irt_pkg::RESP_OKAY : irt_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_mode_q <= irt_pkg::MODE_RESET[irt_pkg::MODE_RELOAD_BIT]; // R09 R20
      clock_select_q <= irt_pkg::MODE_RESET[2:0]; // R20
      out_func_select_q <= irt_pkg::PIN_RESET[irt_pkg::PIN_FUNC_BIT]; // R17
      wave_output_on_q <= irt_pkg::PIN_RESET[irt_pkg::PIN_ON_BIT];
      fixed_rate_pick_q <= irt_pkg::PIN_RESET[irt_pkg::PIN_FIXED_RATE_PICK_BIT];
      toggle_rate_pick_q <= irt_pkg::PIN_RESET[irt_pkg::PIN_TOGGLE_BIT];
      irq_pin_select_q <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
      reload_q <= irt_pkg::RELOAD_RESET; // R08
    end else begin
      if (wr_mode) begin
        reload_mode_q <= wr_byte[irt_pkg::MODE_RELOAD_BIT];
        clock_select_q <= wr_byte[2:0];
      end
      if (wr_pin) begin
        out_func_select_q <= wr_byte[irt_pkg::PIN_FUNC_BIT];
        wave_output_on_q <= wr_byte[irt_pkg::PIN_ON_BIT];
        fixed_rate_pick_q <= wr_byte[irt_pkg::PIN_FIXED_RATE_PICK_BIT];
        toggle_rate_pick_q <= wr_byte[irt_pkg::PIN_TOGGLE_BIT];
      end
      if (wr_pin1) begin
        irq_pin_select_q <= wr_byte[irt_pkg::IRQ_PIN_BIT];
      end
      if (wr_irqen) begin
        overflow_irq_enable_q <= wr_byte[irt_pkg::OVF_BIT];
      end
      if (wr_count) begin
        reload_q <= wr_byte; // R04
      end
    end
  end

  // the prescaler is never cleared by register writes, so a counter load
  // keeps ticks on the same grid; the first tick after a load may come early
  // free-running prescaler; a tap's rising edge is a one-cycle tick
  assign presc_next = presc_q + 13'h0001;
  assign presc_rise = presc_next & ~presc_q; // R21
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_next;
    end
  end

  // clock select tap: bit k rises once every 2^(k+1) clocks
  always_comb begin
    unique case (clock_select_q) // R19
      3'h0: tick = presc_rise[12];
      3'h1: tick = presc_rise[11];
      3'h2: tick = presc_rise[10];
      3'h3: tick = presc_rise[8];
      3'h4: tick = presc_rise[7];
      3'h5: tick = presc_rise[6];
      3'h6: tick = presc_rise[4];
      3'h7: tick = presc_rise[2];
    endcase
  end

  assign overflow = tick && (count_q == 8'hFF); // R02

  // counter; a reload write wins over a same-cycle tick or overflow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= irt_pkg::COUNT_RESET; // R03 R09
    end else if (wr_count) begin
      count_q <= wr_byte; // R05 R22
    end else if (overflow) begin
      count_q <= reload_mode_q ? reload_q : 8'h00; // R06 R07
    end else if (tick) begin
      count_q <= count_q + 8'h01; // R01
    end
  end

  // overflow flag: hardware set beats software clear; irq accept leaves it alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag_q <= 1'b0;
    end else if (overflow) begin
      overflow_flag_q <= 1'b1; // R02 R22
    end else if (wr_irqreq && !wr_byte[irt_pkg::OVF_BIT]) begin
      overflow_flag_q <= 1'b0; // R11
    end
  end

  assign overflow_irq = overflow_flag_q && overflow_irq_enable_q; // R10

  // toggle flip-flop for variable frequency; period set by reload in auto-reload mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle_q <= 1'b0;
    end else if (overflow) begin
      toggle_q <= ~toggle_q; // R14 R15
    end
  end

  // fixed square waves straight from prescaler bits: exact 50% duty
  assign fixed_wave = fixed_rate_pick_q ? presc_q[9] : presc_q[10]; // R13

  // pin stage, registered so the level leaves a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_q <= 1'b0;
    end else if (!wave_output_on_q) begin
      wave_q <= 1'b0; // R12
    end else begin
      wave_q <= toggle_rate_pick_q ? toggle_q : fixed_wave; // R13 R14
    end
  end

  // pin function select; the interrupt input overrides everything
  assign pin_is_irq_input = irq_pin_select_q; // R12
  assign pin_is_port = !irq_pin_select_q && !out_func_select_q;
  assign wave_out_oe = !irq_pin_select_q && out_func_select_q;
  assign wave_out_pin = wave_out_oe && wave_q;

endmodule : irt_timer

// ==== inc/irt_pkg.sv ====
// irt_pkg: register map, field positions, reset values and timing counts
// for the interval / auto-reload timer with square-wave output.
// assumes a 32-bit AXI4-Lite slave with one register per aligned word.
package irt_pkg;
  // byte offsets (the documented addresses are absolute, so a local map is used)
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_COUNT = 5'h04;
  localparam logic [4:0] OFS_PINCTL = 5'h08;
  localparam logic [4:0] OFS_PINMODE1 = 5'h0C;
  localparam logic [4:0] OFS_IRQREQ = 5'h10;
  localparam logic [4:0] OFS_IRQEN = 5'h14;
  // mode register fields
  localparam int MODE_RELOAD_BIT = 7;
  localparam logic [7:0] MODE_RESET = 8'h78;
  localparam logic [7:0] MODE_FIXED_ONES = 8'h78;
  // pin-control fields
  localparam int PIN_FUNC_BIT = 7;
  localparam int PIN_ON_BIT = 6;
  localparam int PIN_FIXED_RATE_PICK_BIT = 5;
  localparam int PIN_TOGGLE_BIT = 4;
  localparam logic [7:0] PIN_RESET = 8'h0F;
  localparam logic [7:0] PIN_FIXED_ONES = 8'h0F;
  // pin mode register one: irq pin select position
  localparam int IRQ_PIN_BIT = 5;
  // irq request / enable: overflow bit position
  localparam int OVF_BIT = 0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  // prescaler: 13-bit free-running divider gives /8 .. /8192
  localparam int PRESC_W = 13;
  // fixed square wave: half periods of clock/2048 and clock/1024
  localparam int SQ_HALF_SLOW = 2048 / 2;
  localparam int SQ_HALF_FAST = 1024 / 2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irt_pkg

// ==== tb/irt_timer_checker.sv ====
// irt_timer_checker: port assertions for the timer, bound into irt_timer.
// assumes one aclk domain and synchronous active-low aresetn.
`timescale 1ns/10ps
module irt_timer_checker (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic overflow_irq, // irq
  input wire logic wave_out_pin, // pin
  input wire logic wave_out_oe, // pin drive
  input wire logic pin_is_port, // port use
  input wire logic pin_is_irq_input // irq input use
);
  logic [10:0] gap_q;
  logic arm_q, pin_q, oe_q, oe_q2;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pin edge spacing; armed only by an edge seen while driven, so turn-on steps never count
  always_ff @(posedge aclk) begin
    pin_q <= wave_out_pin;
    oe_q <= wave_out_oe;
    oe_q2 <= oe_q; // the first wave level shows two samples after drive starts
    if (!aresetn || !wave_out_oe) begin
      gap_q <= 11'h000;
      arm_q <= 1'b0;
    end else if (wave_out_pin != pin_q) begin
      gap_q <= 11'h000;
      arm_q <= oe_q2;
    end else begin
      gap_q <= gap_q + 11'h001;
    end
  end
  irq_pin_a: assert property (pin_is_irq_input |-> !wave_out_oe && !pin_is_port)
    else $error("irq input pin is driven");
  off_low_a: assert property (!wave_out_oe |-> !wave_out_pin)
    else $error("undriven pin shows high");
  port_pin_a: assert property (pin_is_port |-> !wave_out_oe)
    else $error("port pin is driven");
  wave_step_a: assert property (wave_out_oe && arm_q && wave_out_pin != pin_q |-> gap_q[2:0] == 3'h7)
    else $error("pin edge off the 8 cycle grid");
  flag_hold_a: assert property ($fell(overflow_irq) |-> $rose(s_axi_bvalid))
    else $error("irq dropped without a write");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cover property (arm_q && wave_out_pin != pin_q);
  cover property ($rose(overflow_irq));
  cover property (pin_is_irq_input);
endmodule : irt_timer_checker
bind irt_timer irt_timer_checker irt_timer_checker_inst (.*);

// ==== tb/irt_cpu_model.sv ====
// irt_cpu_model: cpu side of the register bus, an AXI4-Lite master run by tasks.
// assumes one task at a time, each entered after a clock edge.
`timescale 1ns/10ps
module irt_cpu_model (
  input wire logic aclk, // clock
  output logic [4:0] s_axi_awaddr, // aw addr
  output logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  output logic [31:0] s_axi_wdata, // w data
  output logic [3:0] s_axi_wstrb, // w strobes
  output logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  output logic s_axi_bready, // b ready
  output logic [4:0] s_axi_araddr, // ar addr
  output logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  output logic s_axi_rready // r ready
);
  // idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
    s_axi_wstrb = 4'hF;
  end
  // write: both phases offered, each released when taken; ready may come a cycle late
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($urandom_range(1));
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask : wr
  // read: address held until taken, data taken at the rready edge
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom_range(1));
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (!s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : irt_cpu_model

// ==== tb/irt_timer_bench.sv ====
// irt_timer_bench: self-checking bench; the cpu model drives the bus and a
// monitor compares every read and write answer with queued notes.
// assumes a 40 MHz aclk and synchronous active-low aresetn.
`timescale 1ns/10ps
module irt_timer_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, overflow_irq, wave_out_pin, wave_out_oe;
  logic pin_is_port, pin_is_irq_input;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [34:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [34:0] note;
  logic [7:0] x;
  logic [7:0] rl[3] = '{8'hFF, 8'hFE, 8'h00};
  int fail_count, check_count;
  irt_timer irt_timer_inst (.*);
  irt_cpu_model irt_cpu_model_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // slack accepts one further count step, for reads racing a prescaler tick
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input logic s = 1'b0);
    check_count++;
    if (got !== exp && !(s && got === {exp[33:8], exp[7:0] + 8'h01})) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [4:0] a, input logic [7:0] d, input logic [1:0] e = irt_pkg::RESP_OKAY);
    exp_b.push_back(e);
    irt_cpu_model_inst.wr(a, d);
  endtask : w
  task automatic r(input logic [4:0] a, input logic [7:0] d, input logic s = 1'b0,
                   input logic [1:0] e = irt_pkg::RESP_OKAY);
    exp_r.push_back({s, e, 24'h000000, d});
    irt_cpu_model_inst.rd(a);
  endtask : r
  // first full half period of the pin, in clock cycles
  task automatic half(input int e);
    logic p;
    int n;
    repeat (2) begin
      p = wave_out_pin;
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (wave_out_pin === p && n < 5000);
    end
    chk(n, e);
  endtask : half
  task automatic reset_dut();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : reset_dut
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // monitor: a finished read or write takes the oldest note off its queue
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      note = exp_r.pop_front();
      chk({s_axi_rresp, s_axi_rdata}, note[33:0], note[34]);
    end
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, exp_b.pop_front());
  end
  // watchdog: the tests need under 8000 cycles
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hE533));
    reset_dut();
    r(irt_pkg::OFS_MODE, 8'h78);
    r(irt_pkg::OFS_PINCTL, 8'h0F);
    r(irt_pkg::OFS_COUNT, 8'h00);
    w(5'h18, 8'h55, irt_pkg::RESP_SLVERR);
    r(5'h18, 8'h00, 1'b0, irt_pkg::RESP_SLVERR);
    w(irt_pkg::OFS_MODE, 8'h81);
    r(irt_pkg::OFS_MODE, 8'hF9);
    w(irt_pkg::OFS_PINCTL, 8'h30);
    r(irt_pkg::OFS_PINCTL, 8'h3F);
    w(irt_pkg::OFS_PINCTL, 8'h00);
    w(irt_pkg::OFS_MODE, 8'h07);
    repeat (4) begin
      x = 8'($urandom);
      w(irt_pkg::OFS_COUNT, x);
      r(irt_pkg::OFS_COUNT, x, 1'b1);
    end
    // interval wrap: FC plus six or seven ticks of 8 cycles
    w(irt_pkg::OFS_COUNT, 8'hFC);
    repeat (48) @(posedge aclk);
    r(irt_pkg::OFS_COUNT, 8'h02, 1'b1);
    w(irt_pkg::OFS_MODE, 8'h87);
    w(irt_pkg::OFS_PINCTL, 8'hF0);
    foreach (rl[i]) begin
      w(irt_pkg::OFS_COUNT, rl[i]);
      half(8 * (256 - rl[i]));
    end
    w(irt_pkg::OFS_IRQEN, 8'h01);
    chk(overflow_irq, 1'b1);
    w(irt_pkg::OFS_IRQEN, 8'h00);
    chk(overflow_irq, 1'b0);
    w(irt_pkg::OFS_PINCTL, 8'h00);
    w(irt_pkg::OFS_PINCTL, 8'hC0);
    half(1024);
    w(irt_pkg::OFS_PINCTL, 8'h00);
    w(irt_pkg::OFS_PINCTL, 8'hE0);
    half(512);
    w(irt_pkg::OFS_MODE, 8'h80);
    w(irt_pkg::OFS_COUNT, 8'hF0);
    w(irt_pkg::OFS_IRQEN, 8'h01);
    chk(overflow_irq, 1'b1);
    w(irt_pkg::OFS_IRQREQ, 8'h00);
    r(irt_pkg::OFS_IRQREQ, 8'h00);
    chk(overflow_irq, 1'b0);
    w(irt_pkg::OFS_PINCTL, 8'h00);
    w(irt_pkg::OFS_PINMODE1, 8'h20);
    w(irt_pkg::OFS_PINCTL, 8'h80);
    chk({pin_is_irq_input, wave_out_oe, pin_is_port, wave_out_pin}, 4'h8);
    w(irt_pkg::OFS_PINMODE1, 8'h00);
    chk({pin_is_irq_input, wave_out_oe, pin_is_port, wave_out_pin}, 4'h4);
    w(irt_pkg::OFS_PINCTL, 8'h00);
    chk({pin_is_irq_input, wave_out_oe, pin_is_port, wave_out_pin}, 4'h2);
    reset_dut();
    r(irt_pkg::OFS_MODE, 8'h78);
    r(irt_pkg::OFS_COUNT, 8'h00);
    repeat (4) @(posedge aclk);
    stop_test();
  end
endmodule : irt_timer_bench
